// ==== include/dual_timer_pkg.sv ====
`default_nettype none
package dual_timer_pkg;
	localparam int HALF_W_DEFAULT = 16;
	localparam int ADDR_W = 6;
	// Register offsets (byte addresses)
	localparam logic [5:0] OFS_CFG = 6'h00;
	localparam logic [5:0] OFS_MODE_A = 6'h04;
	localparam logic [5:0] OFS_MODE_B = 6'h08;
	localparam logic [5:0] OFS_CTRL = 6'h0c;
	localparam logic [5:0] OFS_IMASK = 6'h10;
	localparam logic [5:0] OFS_RIS = 6'h14;
	localparam logic [5:0] OFS_MIS = 6'h18;
	localparam logic [5:0] OFS_ICLR = 6'h1c;
	localparam logic [5:0] OFS_LOAD_A = 6'h20;
	localparam logic [5:0] OFS_LOAD_B = 6'h24;
	localparam logic [5:0] OFS_MATCH_A = 6'h28;
	localparam logic [5:0] OFS_MATCH_B = 6'h2c;
	localparam logic [5:0] OFS_PRE_A = 6'h30;
	localparam logic [5:0] OFS_PRE_B = 6'h34;
	localparam logic [5:0] OFS_PMAT_A = 6'h38;
	localparam logic [5:0] OFS_PMAT_B = 6'h3c;
	// Offset of the sync command, shared with CTRL; the command is a CTRL write with bit CB_SYNC set
	localparam logic [5:0] OFS_SYNC = 6'h0c;
	// Interrupt bit positions (A in 0..3, B in 4..7, RTC in 8)
	localparam int IB_TIMEOUT = 0;
	localparam int IB_CAP_MATCH = 1;
	localparam int IB_CAP_EVENT = 2;
	localparam int IB_MATCH = 3;
	localparam int IB_B_BASE = 4;
	localparam int IB_RTC = 8;
	localparam int NUM_IRQ = 9;
	// RTC divider: 32.768 kHz to one tick per second
	localparam int RTC_DIV = 32768;
	// Control bit positions in CTRL (per half: enable, stall, invert, trigger; B at +8)
	localparam int CB_EN = 0;
	localparam int CB_STALL = 1;
	localparam int CB_INV = 2;
	localparam int CB_TRIG = 3;
	localparam int CB_B_BASE = 8;
	localparam int CB_SYNC = 16;
	// Module configuration
	typedef enum logic [1:0] {
		CFG_SPLIT = 2'b00,
		CFG_FULL_ONESHOT = 2'b01,
		CFG_FULL_PERIODIC = 2'b11,
		CFG_FULL_RTC = 2'b10
	} cfg_t;
	// Half-width mode
	typedef enum logic [2:0] {
		HM_ONESHOT = 3'h0,
		HM_PERIODIC = 3'h1,
		HM_CAP_COUNT = 3'h2,
		HM_CAP_TIME = 3'h3,
		HM_PWM = 3'h4
	} hmode_t;
	typedef enum logic [1:0] {
		EDGE_RISE = 2'h0,
		EDGE_FALL = 2'h1,
		EDGE_BOTH = 2'h3
	} edge_t;
	// Mode register layout: [2:0] mode, [3] count up, [5:4] edge
	typedef struct packed {
		edge_t  edge_sel;
		logic   up;
		hmode_t mode;
	} hcfg_t;
	typedef struct packed {
		logic en;
		logic stall;
		logic inv;
		logic trig;
	} hctl_t;
	typedef struct packed {
		logic timeout;
		logic cap_match;
		logic cap_event;
		logic match;
	} hevt_t;
endpackage
`default_nettype wire

// ==== core/edge_detect.sv ====
`default_nettype none
module edge_detect
	import dual_timer_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  ce,
	input  wire logic  din,
	input  wire edge_t edge_sel,
	output logic       hit
);
	logic prev_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_r <= 1'b0;
		end else if (ce) begin
			prev_r <= din;
		end
	end

	// Edge selection: rising, falling or both
	always_comb begin
		case (edge_sel)
			EDGE_RISE: hit = din & ~prev_r;
			EDGE_FALL: hit = ~din & prev_r;
			EDGE_BOTH: hit = din ^ prev_r;
			default:   hit = 1'b0;
		endcase
	end
endmodule // edge_detect
`default_nettype wire

// ==== core/half_counter.sv ====
`default_nettype none
module half_counter
	import dual_timer_pkg::*;
#(
	parameter int W = HALF_W_DEFAULT
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         run,
	input  wire logic         split,
	input  wire hcfg_t        cfg,
	input  wire logic         reload,
	input  wire logic         pin_hit,
	input  wire logic [W-1:0] load,
	input  wire logic [W-1:0] match,
	input  wire logic [7:0]   pre,
	input  wire logic [7:0]   pmat,
	output logic [W-1:0]      cnt,
	output hevt_t             evt,
	output logic              pwm
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic [7:0]   pre_r;
	logic         stop_r;
	logic         tick;
	logic         capm;
	logic         end_hit;

	assign cnt = cnt_r;
	// Prescaler stretches range in half-width timer modes
	assign tick = !split || (cfg.mode != HM_ONESHOT && cfg.mode != HM_PERIODIC)
		|| pre_r == pre;
	assign end_hit = cfg.up ? (cnt_r == load) : (cnt_r == '0);
	assign capm = cfg.mode == HM_CAP_COUNT && pin_hit && cnt_r == match;

	always_comb begin
		cnt_nxt = cnt_r;
		evt = '0;
		case (cfg.mode)
			HM_ONESHOT, HM_PERIODIC, HM_PWM: begin
				if (tick && !stop_r) begin
					if (end_hit) begin
						evt.timeout = 1'b1;
						if (cfg.mode != HM_ONESHOT) begin
							cnt_nxt = cfg.up ? '0 : load;
						end
					end else begin
						cnt_nxt = cfg.up ? cnt_r + 1'b1 : cnt_r - 1'b1;
					end
					evt.match = (cnt_r == match) && cfg.mode != HM_PWM;
				end
			end
			HM_CAP_COUNT: begin
				if (pin_hit) begin
					evt.cap_event = 1'b1;
					evt.cap_match = capm;
					cnt_nxt = cfg.up ? cnt_r + 1'b1 : cnt_r - 1'b1;
				end
			end
			HM_CAP_TIME: begin
				evt.cap_event = pin_hit;
				cnt_nxt = end_hit ? (cfg.up ? '0 : load)
					: (cfg.up ? cnt_r + 1'b1 : cnt_r - 1'b1);
			end
			default: cnt_nxt = cnt_r;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			pre_r <= 8'h00;
			stop_r <= 1'b0;
			pwm <= 1'b0;
		end else if (ce) begin
			if (reload) begin
				cnt_r <= cfg.up ? '0 : load;
				pre_r <= 8'h00;
				stop_r <= 1'b0;
			end else if (run) begin
				cnt_r <= cnt_nxt;
				pre_r <= tick ? 8'h00 : pre_r + 8'h01;
				if (cfg.mode == HM_ONESHOT && tick && end_hit) begin
					stop_r <= 1'b1;
				end
			end
			// Edge-aligned: high while the next count is above match, which is from reload until match when counting down
			if (cfg.mode == HM_PWM) begin
				pwm <= (cnt_nxt > match);
			end else begin
				pwm <= 1'b0;
			end
		end
	end
endmodule // half_counter
`default_nettype wire

// ==== core/dual_timer.sv ====
// Behaviour
// - Two half counters run alone or join into one full-width counter with RTC.
// - Half width is a parameter, 16 or 32 bits, full width twice that.
// - One-shot stops at zero counting down or at load counting up.
// - Periodic runs to zero or load, reloads and carries on.
// - RTC only in full-width mode, counting a 32.768 kHz input divided to seconds.
// - Capture and PWM are usable only in split mode.
// - Capture counts edges or measures time between edges.
// - Capture edge is rising, falling or both.
// - PWM turns the capture pin into an output carrying an edge-aligned pulse.
// - Per half there is output inversion, trigger enable and debug stall freeze.
// - Capture raises an event flag per edge and, when counting edges, a flag on reaching the match count.
// - Timeout flag at count end and, outside PWM, match flag when count equals match.
// - A sync command reloads counters of several modules together.
// - Synced counters with one load value give comparable capture times.
//
// Implementation choices: the strobed register port and the register offsets.
`default_nettype none
module dual_timer
	import dual_timer_pkg::*;
#(
	parameter int HALF_W = HALF_W_DEFAULT
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic [5:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        RTC_CLK_IN,
	input  wire logic        DBG_STALL,
	input  wire logic        SYNC_IN,
	output logic             SYNC_OUT,
	input  wire logic        PIN_A_IN,
	output logic             PIN_A_OUT,
	output logic             PIN_A_OE,
	input  wire logic        PIN_B_IN,
	output logic             PIN_B_OUT,
	output logic             PIN_B_OE,
	output logic             TRIG_A,
	output logic             TRIG_B,
	output logic             IRQ
);
	localparam int FW = 2 * HALF_W;

	cfg_t                cfg_r;
	hcfg_t               mode_a_r;
	hcfg_t               mode_b_r;
	hctl_t               ctl_a_r;
	hctl_t               ctl_b_r;
	logic [NUM_IRQ-1:0]  ris_r;
	logic [NUM_IRQ-1:0]  imask_r;
	logic [HALF_W-1:0]   load_a_r;
	logic [HALF_W-1:0]   load_b_r;
	logic [HALF_W-1:0]   match_a_r;
	logic [HALF_W-1:0]   match_b_r;
	logic [7:0]          pre_a_r;
	logic [7:0]          pre_b_r;
	logic [7:0]          pmat_a_r;
	logic [7:0]          pmat_b_r;
	logic [FW-1:0]       full_r;
	logic                full_stop_r;
	logic [15:0]         rtc_div_r;
	logic                rtc_pin_r;
	logic                sync_cmd;
	logic                split;
	logic                run_a;
	logic                run_b;
	logic                hit_a;
	logic                hit_b;
	logic [HALF_W-1:0]   cnt_a;
	logic [HALF_W-1:0]   cnt_b;
	hevt_t               evt_a;
	hevt_t               evt_b;
	logic                pwm_a;
	logic                pwm_b;
	logic [NUM_IRQ-1:0]  ev_set;
	logic                full_to;
	logic                full_match;
	logic                rtc_tick;
	logic [FW-1:0]       full_load;
	logic [FW-1:0]       full_match_v;

	function automatic logic [31:0] zx(input logic [HALF_W-1:0] v);
		zx = 32'(v);
	endfunction

	function automatic hcfg_t legal(input hcfg_t c, input logic sp);
		legal = c;
		if (!sp && c.mode > HM_PERIODIC) begin
			legal.mode = HM_PERIODIC;
		end
	endfunction

	assign split = (cfg_r == CFG_SPLIT);
	assign sync_cmd = SYNC_IN | (WR && ADDR == OFS_CTRL && WDATA[CB_SYNC]);
	assign run_a = ctl_a_r.en && !(ctl_a_r.stall && DBG_STALL) && split;
	assign run_b = ctl_b_r.en && !(ctl_b_r.stall && DBG_STALL) && split;
	assign full_load = {load_b_r, load_a_r};
	assign full_match_v = {match_b_r, match_a_r};

	////////////////////////////////////////////////////////////////////////////
	// Edge detectors and half counters

	edge_detect u_edge_a (
		.clk      (CLK_SYS),
		.rst      (RST),
		.ce       (CE),
		.din      (PIN_A_IN),
		.edge_sel (mode_a_r.edge_sel),
		.hit      (hit_a)
	);

	edge_detect u_edge_b (
		.clk      (CLK_SYS),
		.rst      (RST),
		.ce       (CE),
		.din      (PIN_B_IN),
		.edge_sel (mode_b_r.edge_sel),
		.hit      (hit_b)
	);

	half_counter #(.W(HALF_W)) u_half_a (
		.clk     (CLK_SYS),
		.rst     (RST),
		.ce      (CE),
		.run     (run_a),
		.split   (split),
		.cfg     (legal(mode_a_r, split)),
		.reload  (sync_cmd),
		.pin_hit (hit_a),
		.load    (load_a_r),
		.match   (match_a_r),
		.pre     (pre_a_r),
		.pmat    (pmat_a_r),
		.cnt     (cnt_a),
		.evt     (evt_a),
		.pwm     (pwm_a)
	);

	half_counter #(.W(HALF_W)) u_half_b (
		.clk     (CLK_SYS),
		.rst     (RST),
		.ce      (CE),
		.run     (run_b),
		.split   (split),
		.cfg     (legal(mode_b_r, split)),
		.reload  (sync_cmd),
		.pin_hit (hit_b),
		.load    (load_b_r),
		.match   (match_b_r),
		.pre     (pre_b_r),
		.pmat    (pmat_b_r),
		.cnt     (cnt_b),
		.evt     (evt_b),
		.pwm     (pwm_b)
	);

	////////////////////////////////////////////////////////////////////////////
	// Full-width counter and RTC

	assign rtc_tick = (rtc_div_r == 16'(RTC_DIV - 1)) && RTC_CLK_IN && !rtc_pin_r;
	assign full_to = !split && ctl_a_r.en && !full_stop_r && !(ctl_a_r.stall && DBG_STALL)
		&& cfg_r != CFG_FULL_RTC && full_r == '0;
	assign full_match = !split && ctl_a_r.en && !(ctl_a_r.stall && DBG_STALL)
		&& (cfg_r == CFG_FULL_RTC ? rtc_tick && FW'(full_r + 1'b1) == full_match_v
		: !full_stop_r && full_r == full_match_v);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			full_r <= '0;
			full_stop_r <= 1'b0;
			rtc_div_r <= 16'h0000;
			rtc_pin_r <= 1'b0;
		end else if (CE) begin
			rtc_pin_r <= RTC_CLK_IN;
			if (sync_cmd || split) begin
				full_r <= (cfg_r == CFG_FULL_RTC) ? '0 : full_load;
				full_stop_r <= 1'b0;
				rtc_div_r <= 16'h0000;
			end else if (ctl_a_r.en && !(ctl_a_r.stall && DBG_STALL)) begin
				if (cfg_r == CFG_FULL_RTC) begin
					if (RTC_CLK_IN && !rtc_pin_r) begin
						rtc_div_r <= rtc_tick ? 16'h0000 : rtc_div_r + 16'h0001;
					end
					if (rtc_tick) begin
						full_r <= full_r + 1'b1;
					end
				end else if (!full_stop_r) begin
					if (full_r == '0) begin
						full_r <= (cfg_r == CFG_FULL_ONESHOT) ? full_r : full_load;
						full_stop_r <= (cfg_r == CFG_FULL_ONESHOT);
					end else begin
						full_r <= full_r - 1'b1;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status

	always_comb begin
		ev_set = '0;
		if (split) begin
			ev_set[IB_B_BASE +: 4] = evt_b;
			ev_set[3:0] = {evt_a.match, evt_a.cap_event, evt_a.cap_match, evt_a.timeout};
			ev_set[IB_B_BASE +: 4] = {evt_b.match, evt_b.cap_event, evt_b.cap_match,
				evt_b.timeout};
			if (!run_a) ev_set[3:0] = '0;
			if (!run_b) ev_set[IB_B_BASE +: 4] = '0;
		end else begin
			ev_set[IB_TIMEOUT] = full_to;
			ev_set[IB_MATCH] = full_match && cfg_r != CFG_FULL_RTC;
			ev_set[IB_RTC] = full_match && cfg_r == CFG_FULL_RTC;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ris_r <= '0;
		end else if (CE) begin
			// Set wins over clear
			ris_r <= (ris_r & ~((RD && ADDR == OFS_RIS) ? ris_r : '0)
				& ~((WR && ADDR == OFS_ICLR) ? WDATA[NUM_IRQ-1:0] : '0)) | ev_set;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else if (CE) begin
			IRQ <= |(ris_r & imask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pins and triggers

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			PIN_A_OUT <= 1'b0;
			PIN_A_OE <= 1'b0;
			PIN_B_OUT <= 1'b0;
			PIN_B_OE <= 1'b0;
			TRIG_A <= 1'b0;
			TRIG_B <= 1'b0;
			SYNC_OUT <= 1'b0;
		end else if (CE) begin
			PIN_A_OE <= split && mode_a_r.mode == HM_PWM;
			PIN_B_OE <= split && mode_b_r.mode == HM_PWM;
			PIN_A_OUT <= pwm_a ^ ctl_a_r.inv;
			PIN_B_OUT <= pwm_b ^ ctl_b_r.inv;
			TRIG_A <= ctl_a_r.trig && (ev_set[IB_TIMEOUT] || ev_set[IB_RTC]);
			TRIG_B <= ctl_b_r.trig && ev_set[IB_B_BASE + IB_TIMEOUT];
			SYNC_OUT <= WR && ADDR == OFS_CTRL && WDATA[CB_SYNC];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cfg_r <= CFG_SPLIT;
			mode_a_r <= '0;
			mode_b_r <= '0;
			ctl_a_r <= '0;
			ctl_b_r <= '0;
			imask_r <= '0;
			load_a_r <= '1;
			load_b_r <= '1;
			match_a_r <= '0;
			match_b_r <= '0;
			pre_a_r <= 8'h00;
			pre_b_r <= 8'h00;
			pmat_a_r <= 8'h00;
			pmat_b_r <= 8'h00;
		end else if (CE && WR) begin
			case (ADDR)
				OFS_CFG:     cfg_r <= cfg_t'(WDATA[1:0]);
				OFS_MODE_A:  mode_a_r <= hcfg_t'(WDATA[5:0]);
				OFS_MODE_B:  mode_b_r <= hcfg_t'(WDATA[5:0]);
				OFS_CTRL: begin
					ctl_a_r <= {WDATA[CB_EN], WDATA[CB_STALL], WDATA[CB_INV], WDATA[CB_TRIG]};
					ctl_b_r <= {WDATA[CB_B_BASE + CB_EN], WDATA[CB_B_BASE + CB_STALL],
						WDATA[CB_B_BASE + CB_INV], WDATA[CB_B_BASE + CB_TRIG]};
				end
				OFS_IMASK:   imask_r <= WDATA[NUM_IRQ-1:0];
				OFS_LOAD_A:  load_a_r <= WDATA[HALF_W-1:0];
				OFS_LOAD_B:  load_b_r <= WDATA[HALF_W-1:0];
				OFS_MATCH_A: match_a_r <= WDATA[HALF_W-1:0];
				OFS_MATCH_B: match_b_r <= WDATA[HALF_W-1:0];
				OFS_PRE_A:   pre_a_r <= WDATA[7:0];
				OFS_PRE_B:   pre_b_r <= WDATA[7:0];
				OFS_PMAT_A:  pmat_a_r <= WDATA[7:0];
				OFS_PMAT_B:  pmat_b_r <= WDATA[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads; load offsets return current count

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RDATA <= 32'h0000_0000;
		end else if (CE) begin
			RDATA <= 32'h0000_0000;
			if (RD) begin
				case (ADDR)
					OFS_CFG:     RDATA <= 32'(cfg_r);
					OFS_MODE_A:  RDATA <= 32'(mode_a_r);
					OFS_MODE_B:  RDATA <= 32'(mode_b_r);
					OFS_CTRL:    RDATA <= {20'h00000, ctl_b_r.trig, ctl_b_r.inv, ctl_b_r.stall,
						ctl_b_r.en, 4'h0, ctl_a_r.trig, ctl_a_r.inv, ctl_a_r.stall, ctl_a_r.en};
					OFS_IMASK:   RDATA <= 32'(imask_r);
					OFS_RIS:     RDATA <= 32'(ris_r);
					OFS_MIS:     RDATA <= 32'(ris_r & imask_r);
					OFS_LOAD_A:  RDATA <= split ? zx(cnt_a) : 32'(full_r[HALF_W-1:0]);
					OFS_LOAD_B:  RDATA <= split ? zx(cnt_b) : 32'(full_r[FW-1:HALF_W]);
					OFS_MATCH_A: RDATA <= zx(match_a_r);
					OFS_MATCH_B: RDATA <= zx(match_b_r);
					OFS_PRE_A:   RDATA <= 32'(pre_a_r);
					OFS_PRE_B:   RDATA <= 32'(pre_b_r);
					OFS_PMAT_A:  RDATA <= 32'(pmat_a_r);
					OFS_PMAT_B:  RDATA <= 32'(pmat_b_r);
					default:     RDATA <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // dual_timer
`default_nettype wire

// ==== dv/dual_timer_assertions.sv ====
`default_nettype none
module dual_timer_checker
	import dual_timer_pkg::*;
(
	input wire logic        CLK_SYS,
	input wire logic        RST,
	input wire logic        CE,
	input wire logic [5:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        SYNC_OUT,
	input wire logic        PIN_A_OE,
	input wire logic        PIN_B_OE,
	input wire logic        TRIG_A,
	input wire logic        TRIG_B,
	input wire logic        IRQ
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	logic [1:0]         cfg_sh;
	logic [2:0]         mda_sh;
	logic [2:0]         mdb_sh;
	logic [15:0]        ctl_sh;
	logic [NUM_IRQ-1:0] msk_sh;
	logic [2:0]         age_r;
	wire                wr_ok = CE & WR;
	wire                sync_wr = wr_ok & (ADDR == OFS_CTRL) & WDATA[CB_SYNC];
	////////////////////////////////////////////////////////////////
	// Shadow of the configuration written over the bus
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			cfg_sh <= 2'h0;
			mda_sh <= 3'h0;
			mdb_sh <= 3'h0;
			ctl_sh <= 16'h0;
			msk_sh <= '0;
		end else if (wr_ok) begin
			case (ADDR)
				OFS_CFG: cfg_sh <= WDATA[1:0];
				OFS_MODE_A: mda_sh <= WDATA[2:0];
				OFS_MODE_B: mdb_sh <= WDATA[2:0];
				OFS_CTRL: ctl_sh <= WDATA[15:0];
				OFS_IMASK: msk_sh <= WDATA[NUM_IRQ-1:0];
				default: ;
			endcase
		end
	end
	// Cycles since the last write, saturating
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST)
			age_r <= 3'h0;
		else if (wr_ok)
			age_r <= 3'h0;
		else if (age_r != 3'h4)
			age_r <= age_r + 3'h1;
	end
	////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(RD & CE) |-> RDATA == 32'h0)
		else $error("read data not zero outside a read answer");
	a_sync_cause: assert property (SYNC_OUT |-> $past(sync_wr))
		else $error("sync pulse without a sync command");
	a_sync_resp: assert property (sync_wr |=> SYNC_OUT)
		else $error("sync command gave no sync pulse");
	a_pwm_oe_a: assert property (age_r == 3'h4 |->
		PIN_A_OE == (cfg_sh == CFG_SPLIT && mda_sh == HM_PWM))
		else $error("first pin enable disagrees with mode");
	a_pwm_oe_b: assert property (age_r == 3'h4 |->
		PIN_B_OE == (cfg_sh == CFG_SPLIT && mdb_sh == HM_PWM))
		else $error("second pin enable disagrees with mode");
	a_trig_en_a: assert property (TRIG_A |-> ctl_sh[CB_TRIG] || $past(ctl_sh[CB_TRIG]))
		else $error("first trigger while disabled");
	a_trig_en_b: assert property (TRIG_B |->
		ctl_sh[CB_B_BASE+CB_TRIG] || $past(ctl_sh[CB_B_BASE+CB_TRIG]))
		else $error("second trigger while disabled");
	a_trig_one_a: assert property (TRIG_A |=> !TRIG_A)
		else $error("first trigger longer than one cycle");
	a_irq_masked: assert property (IRQ |-> $past(msk_sh) != '0)
		else $error("interrupt with all sources masked");
	c_sync: cover property (SYNC_OUT);
	c_pwm: cover property (PIN_B_OE);
	c_irq: cover property (IRQ);
	c_trig: cover property (TRIG_A);
endmodule // dual_timer_checker
bind dual_timer dual_timer_checker u_dual_timer_checker (
	.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .SYNC_OUT(SYNC_OUT),
	.PIN_A_OE(PIN_A_OE), .PIN_B_OE(PIN_B_OE), .TRIG_A(TRIG_A),
	.TRIG_B(TRIG_B), .IRQ(IRQ));
`default_nettype wire

// ==== dv/dual_timer_pin_model.sv ====
`default_nettype none
module dual_timer_pin_model (
	input wire logic clk,
	input wire logic a_out,
	input wire logic a_oe,
	input wire logic b_out,
	input wire logic b_oe,
	output logic     a_in,
	output logic     b_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lvl_a = 1'b0;
	logic b_q = 1'b0;
	int   b_rises = 0;
	// Driven pin level wins over the external source
	assign a_in = a_oe ? a_out : lvl_a;
	assign b_in = b_oe ? b_out : 1'b0;
	always @(posedge clk) begin
		b_q <= b_in;
		if (b_in && !b_q)
			b_rises <= b_rises + 1;
	end
	task automatic set_a(input logic v);
		@(posedge clk);
		lvl_a <= v;
	endtask
endmodule // dual_timer_pin_model
`default_nettype wire

// ==== dv/dual_timer_tb_top.sv ====
`default_nettype none
module dual_timer_tb_top
	import dual_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [31:0] v; logic [31:0] m;} note_t;
	localparam logic [31:0] HM = 32'h0000ffff;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic        clk = 1'b0;
	logic        rst, wr, rd, rd_q, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, irq;
	logic        stall, sync_in, trig_a, trig_b;
	logic [5:0]  addr;
	logic [31:0] wdata, rdata, r;
	integer      seed;
	int          n_errors = 0, check_count = 0, cyc = 0, i, k, e;
	int          n_trig_a = 0, n_trig_b = 0;
	note_t       q[$];
	note_t       n;
	always #10 clk = ~clk;
	dual_timer u_dual_timer (.CLK_SYS(clk), .RST(rst), .CE(1'b1), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RTC_CLK_IN(1'b0),
		.DBG_STALL(stall), .SYNC_IN(sync_in), .SYNC_OUT(), .PIN_A_IN(pa_in),
		.PIN_A_OUT(pa_out), .PIN_A_OE(pa_oe), .PIN_B_IN(pb_in), .PIN_B_OUT(pb_out),
		.PIN_B_OE(pb_oe), .TRIG_A(trig_a), .TRIG_B(trig_b), .IRQ(irq));
	dual_timer_pin_model u_dual_timer_pin_model (.clk(clk), .a_out(pa_out), .a_oe(pa_oe),
		.b_out(pb_out), .b_oe(pb_oe), .a_in(pa_in), .b_in(pb_in));
	////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (x !== g) begin
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
			n_errors++;
		end
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [5:0] a, input logic [31:0] v, input logic [31:0] m);
		q.push_back('{v: v & m, m: m});
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic wait_irq(input int lim);
		for (k = 0; k < lim && irq !== 1'b1; k++)
			@(posedge clk);
		@(negedge clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Read answers are compared against the oldest note
	always @(posedge clk) rd_q <= rd;
	// Trigger pulses are counted as they stand
	always @(posedge clk) begin
		n_trig_a += int'(trig_a === 1'b1);
		n_trig_b += int'(trig_b === 1'b1);
	end
	always @(negedge clk) begin
		if (rd_q && q.size() > 0) begin
			n = q.pop_front();
			check("rdata", n.v, rdata & n.m);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h5d80;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 6'h00;
		wdata = 32'h0;
		stall = 1'b0;
		sync_in = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Reset values and an unaligned address
		rd_reg(OFS_CFG, 32'h0, ALL);
		rd_reg(OFS_MODE_A, 32'h0, ALL);
		rd_reg(OFS_IMASK, 32'h0, ALL);
		rd_reg(OFS_RIS, 32'h0, ALL);
		rd_reg(6'h01, 32'h0, ALL);
		// Match and prescale read back, then cleared
		for (i = 0; i < 4; i++) begin
			r = $random(seed);
			wr_reg(OFS_MATCH_A + 6'(4 * i), r);
			rd_reg(OFS_MATCH_A + 6'(4 * i), r, i < 2 ? HM : 32'hff);
			wr_reg(OFS_MATCH_A + 6'(4 * i), 32'h0);
		end
		// One-shot down: sync reload, stall freeze, then timeout and match flags
		wr_reg(OFS_IMASK, 32'h1 << IB_TIMEOUT);
		wr_reg(OFS_LOAD_A, 32'd20);
		wr_reg(OFS_MATCH_A, 32'd10);
		sync_in <= 1'b1;
		@(posedge clk);
		sync_in <= 1'b0;
		wr_reg(OFS_CTRL, (32'h1 << CB_EN) | (32'h1 << CB_STALL) | (32'h1 << CB_TRIG));
		stall <= 1'b1;
		rd_reg(OFS_CTRL, 32'hb, 32'hf0f);
		repeat (4) @(posedge clk);
		rd_reg(OFS_LOAD_A, 32'd20, HM);
		stall <= 1'b0;
		wait_irq(200);
		check("irq", 32'h1, {31'h0, irq});
		check("trig_a", 32'h1, 32'(n_trig_a));
		repeat (5) @(posedge clk);
		rd_reg(OFS_LOAD_A, 32'h0, HM);
		rd_reg(OFS_RIS, 32'h9, 32'h1ff);
		rd_reg(OFS_RIS, 32'h0, 32'h1ff);
		// Periodic up on the second half keeps timing out
		wr_reg(OFS_CTRL, 32'h0);
		wr_reg(OFS_MODE_B, {26'h0, EDGE_RISE, 1'b1, HM_PERIODIC});
		wr_reg(OFS_LOAD_B, 32'd9);
		wr_reg(OFS_IMASK, 32'h1 << (IB_B_BASE + IB_TIMEOUT));
		wr_reg(OFS_CTRL, 32'h9 << CB_B_BASE);
		wait_irq(100);
		wr_reg(OFS_ICLR, 32'h1 << (IB_B_BASE + IB_TIMEOUT));
		repeat (3) @(posedge clk);
		wait_irq(40);
		check("irq", 32'h1, {31'h0, irq});
		check("trig_b", 32'h1, {31'h0, n_trig_b >= 2});
		wr_reg(OFS_IMASK, 32'h0);
		// Capture edge selection on the first half
		wr_reg(OFS_CTRL, 32'h0);
		for (e = 0; e < 3; e++) begin
			wr_reg(OFS_MODE_A, {26'h0, e == 2 ? EDGE_BOTH : edge_t'(e), 1'b0, HM_CAP_COUNT});
			wr_reg(OFS_LOAD_A, 32'd100);
			wr_reg(OFS_CTRL, 32'h1 << CB_EN);
			rd_reg(OFS_RIS, 32'h0, 32'h4);
			u_dual_timer_pin_model.set_a(1'b1);
			repeat (6) @(posedge clk);
			rd_reg(OFS_RIS, {29'h0, e != 1, 2'h0}, 32'h4);
			u_dual_timer_pin_model.set_a(1'b0);
			repeat (6) @(posedge clk);
			rd_reg(OFS_RIS, {29'h0, e != 0, 2'h0}, 32'h4);
			wr_reg(OFS_CTRL, 32'h0);
		end
		// PWM on the second half, then full width drops the pin
		wr_reg(OFS_MODE_B, {29'h0, HM_PWM});
		wr_reg(OFS_LOAD_B, 32'd9);
		wr_reg(OFS_MATCH_B, 32'd4);
		wr_reg(OFS_CTRL, 32'h1 << (CB_B_BASE + CB_EN));
		repeat (10) @(posedge clk);
		check("pin_b_oe", 32'h1, {31'h0, pb_oe});
		k = u_dual_timer_pin_model.b_rises;
		repeat (100) @(posedge clk);
		k = u_dual_timer_pin_model.b_rises - k;
		check("pwm_edges", 32'h1, {31'h0, k >= 9 && k <= 11});
		wr_reg(OFS_CFG, {30'h0, CFG_FULL_PERIODIC});
		repeat (6) @(posedge clk);
		check("pin_b_oe", 32'h0, {31'h0, pb_oe});
		// Full-width one-shot stops at zero with a timeout flag
		wr_reg(OFS_CFG, {30'h0, CFG_FULL_ONESHOT});
		wr_reg(OFS_LOAD_A, 32'd5);
		wr_reg(OFS_LOAD_B, 32'd0);
		wr_reg(OFS_CTRL, 32'h1 << CB_SYNC);
		wr_reg(OFS_CTRL, 32'h1 << CB_EN);
		repeat (20) @(posedge clk);
		rd_reg(OFS_LOAD_A, 32'h0, ALL);
		rd_reg(OFS_RIS, 32'h1, 32'h1);
		repeat (4) @(posedge clk);
		end_of_test;
	end
endmodule // dual_timer_tb_top
`default_nettype wire
